/* core/adc_key_ctl.sv */
// Purpose: control of an 8-channel 10-bit SAR converter with key detect
// Assumes: analog front end gives a comparator level; inputs synchronous
// Notes: one clock, clock enable freezes all state
// Functional notes
// R1 - key detect overrides channel select bits
// R2 - stored channel field unchanged by key detect
// R3 - software avoids program start under key detect
// R4 - first result after key start is undefined
// R5 - software selects key channel to measure it
// R6 - key pin settles within eight clocks
// R7 - main clock at least 500 kHz
// R8 - low-speed mode clocks from on-chip oscillator
// R9 - no stop or wait during conversion
// R10 - no control writes during conversion
// R11 - store result and raise done flag
`timescale 1ns/1ps
module adc_key_ctl (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic main_tick_i,
   input wire logic osc_tick_i,
   input wire logic low_speed_i,
   input wire logic ctl_wr_i,
   input wire logic [2:0] ch_sel_i,
   input wire logic analog_key_detect_en_i,
   input wire logic start_i,
   input wire logic done_clr_i,
   input wire logic key_pin_i,
   input wire logic cmp_hi_i,
   output logic [2:0] ch_sel_o,
   output logic [2:0] mux_ch_o,
   output logic [9:0] dac_code_o,
   output logic sampling_o,
   output logic busy_o,
   output logic [9:0] result_o,
   output logic done_o,
   output logic result_undef_o,
   output logic key_event_o
);
   adc_ctl_pkg::adc_state_e state_ff, nxt_state;
   logic [2:0] ch_ff;
   logic key_en_ff;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [3:0] bit_ff, nxt_bit;
   logic [9:0] code_ff, nxt_code;
   logic [9:0] result_ff;
   logic done_ff;
   logic undef_ff;
   logic first_key_ff;
   logic key_prev_ff;
   logic [3:0] settle_ff;
   logic key_event_ff;
   logic [9:0] keep_w;
   logic [9:0] trial_w;

   // conversion clock source by operating mode
   wire tick = low_speed_i ? osc_tick_i : main_tick_i; // R8
   // key detect takes the mux, stored field stays
   wire [2:0] conv_ch = key_en_ff ? adc_ctl_pkg::KEY_CH : ch_ff; // R1
   wire key_fall = key_prev_ff & ~key_pin_i;
   wire key_start = key_en_ff & (settle_ff == adc_ctl_pkg::CNT_ONE) & tick & ~key_pin_i;
   wire go = (state_ff == adc_ctl_pkg::ST_IDLE) & ((start_i & ~key_en_ff) | key_start);
   wire last_bit = (bit_ff == adc_ctl_pkg::BIT_ZERO);
   wire finish = (state_ff == adc_ctl_pkg::ST_CONVERT) & tick & last_bit;
   // enable rising by a control write marks the next key result
   wire key_turn_on = ctl_wr_i & analog_key_detect_en_i & ~key_en_ff;
   wire key_result = finish & key_en_ff;
   wire settle_clear = ~key_en_ff | key_pin_i;
   wire settle_run = tick & (settle_ff != adc_ctl_pkg::CNT_ZERO);

   sar_step u_step (
      .cur_i(code_ff),
      .bit_i(bit_ff),
      .cmp_hi_i(cmp_hi_i),
      .keep_o(keep_w),
      .trial_o(trial_w)
   );

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_bit = bit_ff;
      nxt_code = code_ff;
      case (state_ff)
         adc_ctl_pkg::ST_IDLE: begin
            if (go) begin
               nxt_state = adc_ctl_pkg::ST_SAMPLE;
               nxt_cnt = adc_ctl_pkg::SAMPLE_TICKS;
               nxt_code = adc_ctl_pkg::RES_MSB;
               nxt_bit = adc_ctl_pkg::BIT_TOP;
            end
         end
         adc_ctl_pkg::ST_SAMPLE: begin
            if (tick) begin
               nxt_cnt = cnt_ff - adc_ctl_pkg::CNT_ONE;
               if (cnt_ff == adc_ctl_pkg::CNT_ONE) begin
                  nxt_state = adc_ctl_pkg::ST_CONVERT;
               end
            end
         end
         adc_ctl_pkg::ST_CONVERT: begin
            if (tick) begin
               if (last_bit) begin
                  nxt_code = keep_w;
                  nxt_state = adc_ctl_pkg::ST_DONE;
               end else begin
                  nxt_code = trial_w;
                  nxt_bit = bit_ff - adc_ctl_pkg::CNT_ONE;
               end
            end
         end
         adc_ctl_pkg::ST_DONE: begin
            nxt_state = adc_ctl_pkg::ST_IDLE;
         end
         default: begin
            nxt_state = adc_ctl_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_ff <= adc_ctl_pkg::ST_IDLE;
         cnt_ff <= adc_ctl_pkg::CNT_ZERO;
         bit_ff <= adc_ctl_pkg::BIT_ZERO;
         code_ff <= adc_ctl_pkg::RES_RESET;
      end else if (ce_i) begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         bit_ff <= nxt_bit;
         code_ff <= nxt_code;
      end
   end

   // control register: channel field written only by software
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ch_ff <= adc_ctl_pkg::CH_RESET;
         key_en_ff <= 1'h0;
      end else if (ce_i && ctl_wr_i) begin
         ch_ff <= ch_sel_i; // R2
         key_en_ff <= analog_key_detect_en_i;
      end
   end

   // key pin history, idle level high
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         key_prev_ff <= 1'h1;
      end else if (ce_i) begin
         key_prev_ff <= key_pin_i;
      end
   end

   // one-cycle marker of a key press
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         key_event_ff <= 1'h0;
      end else if (ce_i) begin
         key_event_ff <= key_en_ff & key_fall;
      end
   end

   // settle window counted on converter ticks
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         settle_ff <= adc_ctl_pkg::CNT_ZERO;
      end else if (ce_i) begin
         if (settle_clear) begin
            settle_ff <= adc_ctl_pkg::CNT_ZERO;
         end else if (key_fall) begin
            settle_ff <= adc_ctl_pkg::KEY_SETTLE_TICKS; // R6
         end else if (settle_run) begin
            settle_ff <= settle_ff - adc_ctl_pkg::CNT_ONE;
         end
      end
   end

   // first key result after enable is flagged
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         first_key_ff <= 1'h0;
      end else if (ce_i) begin
         if (key_turn_on) begin
            first_key_ff <= 1'h1;
         end else if (key_result) begin
            first_key_ff <= 1'h0;
         end
      end
   end

   // result register
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         result_ff <= adc_ctl_pkg::RES_RESET;
      end else if (ce_i && finish) begin
         result_ff <= keep_w; // R11
      end
   end

   // done flag, a finish beats a clear
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         done_ff <= 1'h0;
      end else if (ce_i) begin
         if (finish) begin
            done_ff <= 1'h1; // R11
         end else if (done_clr_i) begin
            done_ff <= 1'h0;
         end
      end
   end

   // undefined marker follows each finish
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         undef_ff <= 1'h0;
      end else if (ce_i && finish) begin
         undef_ff <= key_result & first_key_ff; // R4
      end
   end

   assign ch_sel_o = ch_ff;
   assign mux_ch_o = conv_ch;
   assign dac_code_o = code_ff;
   assign sampling_o = (state_ff == adc_ctl_pkg::ST_SAMPLE);
   assign busy_o = (state_ff != adc_ctl_pkg::ST_IDLE);
   assign result_o = result_ff;
   assign done_o = done_ff;
   assign result_undef_o = undef_ff;
   assign key_event_o = key_event_ff;
endmodule

/* core/adc_ctl_pkg.sv */
// Purpose: constants shared by the converter control logic
// Assumes: 10 MHz system clock, 10-bit result, 8 channels
// Notes: timing counts are in converter clock ticks
package adc_ctl_pkg;
   localparam int CH_W = 3;
   localparam int RES_W = 10;
   localparam int NUM_CH = 8;
   localparam logic [2:0] CH_RESET = 3'h0;
   // channel wired to the key-detect pin
   localparam logic [2:0] KEY_CH = 3'h7;
   localparam logic [9:0] RES_RESET = 10'h000;
   localparam logic [9:0] RES_MSB = 10'h200;
   localparam logic [3:0] BIT_TOP = 4'h9;
   localparam logic [3:0] BIT_ZERO = 4'h0;
   // sample phase length, converter clock ticks
   localparam logic [3:0] SAMPLE_TICKS = 4'h8;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;
   // key pin settle window, converter clock ticks
   localparam logic [3:0] KEY_SETTLE_TICKS = 4'h8;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_SAMPLE = 2'h1,
      ST_CONVERT = 2'h3,
      ST_DONE = 2'h2
   } adc_state_e;
endpackage

/* core/sar_step.sv */
// Purpose: one successive-approximation step of the result
// Assumes: comparator output valid when step is asserted
// Notes: purely combinational trial-bit update
`timescale 1ns/1ps
module sar_step (
   input wire logic [9:0] cur_i,
   input wire logic [3:0] bit_i,
   input wire logic cmp_hi_i,
   output logic [9:0] keep_o,
   output logic [9:0] trial_o
);
   wire [9:0] mask = adc_ctl_pkg::RES_MSB >> (adc_ctl_pkg::BIT_TOP - bit_i);
   wire [9:0] next_mask = mask >> 1;
   // clear trial bit when comparator says input is below
   assign keep_o = cmp_hi_i ? cur_i : (cur_i & ~mask);
   assign trial_o = keep_o | next_mask;
endmodule

/* test/analog_front.sv */
// Purpose: comparator model of the analog inputs
// Assumes: ideal comparator, one level per channel
// Notes: answers in the same cycle
`timescale 1ns/1ps
module analog_front (
   input wire logic [2:0] ch_i,
   input wire logic [9:0] code_i,
   input wire logic [7:0][9:0] lvl_i,
   output logic cmp_hi_o
);
   assign cmp_hi_o = lvl_i[ch_i] >= code_i;
endmodule

/* test/adc_key_ctl_asserts.sv */
// Purpose: port checks of the converter control
// Assumes: one clock, sync reset
// Notes: key enable is mirrored here
`timescale 1ns/1ps
module adc_key_ctl_asserts (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic ctl_wr_i,
   input wire logic [2:0] ch_sel_i,
   input wire logic analog_key_detect_en_i,
   input wire logic start_i,
   input wire logic done_clr_i,
   input wire logic [2:0] ch_sel_o,
   input wire logic [2:0] mux_ch_o,
   input wire logic [9:0] dac_code_o,
   input wire logic sampling_o,
   input wire logic busy_o,
   input wire logic [9:0] result_o,
   input wire logic done_o,
   input wire logic result_undef_o,
   input wire logic key_event_o
);
   logic key_ff;
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) key_ff <= 1'b0;
      else if (ce_i && ctl_wr_i) key_ff <= analog_key_detect_en_i;
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   key_mux_a: assert property (mux_ch_o == (key_ff ? adc_ctl_pkg::KEY_CH : ch_sel_o))
      else $error("mux channel wrong");
   ch_write_a: assert property (ce_i && ctl_wr_i |=> ch_sel_o == $past(ch_sel_i))
      else $error("channel field wrong");
   start_go_a: assert property (ce_i && start_i && !busy_o && !key_ff |=> busy_o && sampling_o)
      else $error("start not taken");
   sample_code_a: assert property (sampling_o |-> busy_o && dac_code_o == adc_ctl_pkg::RES_MSB)
      else $error("sample code wrong");
   done_end_a: assert property (!$past(rst_i) && $fell(busy_o) && !$past(done_clr_i) |-> done_o)
      else $error("done missing");
   res_hold_a: assert property (!$past(rst_i) && !$stable(result_o) |-> done_o && busy_o)
      else $error("result moved");
   done_stick_a: assert property (done_o && !done_clr_i |=> done_o)
      else $error("done lost");
   undef_flag_a: assert property ($rose(result_undef_o) |-> done_o)
      else $error("undef flag early");
   key_pulse_a: assert property (ce_i && key_event_o |=> !key_event_o)
      else $error("key event too long");
endmodule
bind adc_key_ctl adc_key_ctl_asserts chk (.sys_clk_i, .rst_i, .ce_i, .ctl_wr_i, .ch_sel_i,
   .analog_key_detect_en_i, .start_i, .done_clr_i, .ch_sel_o, .mux_ch_o, .dac_code_o,
   .sampling_o, .busy_o, .result_o, .done_o, .result_undef_o, .key_event_o);

/* test/adc_control_with_key_detect_test.sv */
// Purpose: self-checking bench of the converter control
// Assumes: ideal comparator model
// Notes: random ticks and clock enable
`timescale 1ns/1ps
`define CHK(n, e, a) begin \
   n_checks++; \
   if ((a) !== (e)) begin \
      mismatches++; \
      $display("[ERR] %s exp %h got %h", n, e, a); \
   end \
end
module adc_control_with_key_detect_test;
   logic sys_clk_i = 0, rst_i = 1, ce_i = 1, main_tick_i = 0, osc_tick_i = 0, low_speed_i = 0;
   logic ctl_wr_i = 0, start_i = 0, done_clr_i = 0, key_pin_i = 1, analog_key_detect_en_i = 0, dq = 0;
   logic [2:0] ch_sel_i = 3'h0, ch_sel_o, mux_ch_o;
   logic [9:0] dac_code_o, result_o;
   logic [7:0][9:0] lvl;
   logic sampling_o, busy_o, done_o, result_undef_o, key_event_o, cmp_hi_i;
   logic kq = 1'h0;
   logic [10:0] exp_q [$];
   logic [10:0] e;
   logic [31:0] rs = 32'h0000c4f2;
   int mismatches = 0, n_checks = 0, n_key = 0;
   adc_key_ctl uut (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .main_tick_i(main_tick_i),
      .osc_tick_i(osc_tick_i),
      .low_speed_i(low_speed_i),
      .ctl_wr_i(ctl_wr_i),
      .ch_sel_i(ch_sel_i),
      .analog_key_detect_en_i(analog_key_detect_en_i),
      .start_i(start_i),
      .done_clr_i(done_clr_i),
      .key_pin_i(key_pin_i),
      .cmp_hi_i(cmp_hi_i),
      .ch_sel_o(ch_sel_o),
      .mux_ch_o(mux_ch_o),
      .dac_code_o(dac_code_o),
      .sampling_o(sampling_o),
      .busy_o(busy_o),
      .result_o(result_o),
      .done_o(done_o),
      .result_undef_o(result_undef_o),
      .key_event_o(key_event_o)
   );
   analog_front fe (.ch_i(mux_ch_o), .code_i(dac_code_o), .lvl_i(lvl), .cmp_hi_o(cmp_hi_i));
   function logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   task complete_run();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task cyc(input logic s, input logic w, input logic c);
      @(negedge sys_clk_i);
      ce_i = 1;
      start_i = s;
      ctl_wr_i = w;
      done_clr_i = c;
      @(negedge sys_clk_i);
      {start_i, ctl_wr_i, done_clr_i} = 3'h0;
   endtask
   task waitd();
      for (int i = 0; i < 3000 && done_o !== 1'b1; i++) begin
         @(negedge sys_clk_i);
         ce_i = rnd() % 4 != 0;
      end
      if (done_o !== 1'b1) begin
         mismatches++;
         complete_run();
      end else cyc(0, 0, 1);
   endtask
   initial forever #50 sys_clk_i = ~sys_clk_i;
   always @(negedge sys_clk_i) begin
      main_tick_i = rs[0] && !low_speed_i;
      osc_tick_i = rs[1];
      if (done_o === 1'b1 && dq !== 1'b1) begin
         if (exp_q.size() == 0) begin
            `CHK("queue", 1'h1, 1'h0)
         end else begin
            e = exp_q.pop_front();
            if (e[10]) `CHK("undef", 1'b1, result_undef_o)
            else `CHK("result", e, ({result_undef_o, result_o}))
         end
      end
      if (key_event_o === 1'h1 && kq !== 1'h1) n_key++;
      kq <= key_event_o;
      dq <= done_o;
   end
   initial begin
      for (int k = 0; k < 8; k++) lvl[k] = 10'(rnd());
      repeat (20) @(negedge sys_clk_i);
      rst_i = 0;
      for (int k = 0; k < 8; k++) begin
         low_speed_i = k[0];
         ch_sel_i = 3'(k);
         cyc(0, 1, 0);
         `CHK("mux", ch_sel_i, mux_ch_o)
         exp_q.push_back({1'b0, lvl[k]});
         cyc(1, 0, 0);
         waitd();
      end
      $display("channel test done");
      analog_key_detect_en_i = 1;
      ch_sel_i = 3'h3;
      cyc(0, 1, 0);
      `CHK("chsel", 3'h3, ch_sel_o)
      `CHK("keymux", 3'h7, mux_ch_o)
      cyc(1, 0, 0);
      `CHK("busy", 1'b0, busy_o)
      for (int k = 0; k < 2; k++) begin
         exp_q.push_back({k == 0, lvl[7]});
         key_pin_i = 0;
         waitd();
         key_pin_i = 1;
         cyc(0, 0, 0);
      end
      `CHK("keyevt", 32'h2, n_key)
      $display("key test done");
      analog_key_detect_en_i = 0;
      ch_sel_i = adc_ctl_pkg::KEY_CH;
      cyc(0, 1, 0);
      `CHK("keych", adc_ctl_pkg::KEY_CH, ch_sel_o)
      exp_q.push_back({1'h0, lvl[adc_ctl_pkg::KEY_CH]});
      cyc(1, 0, 0);
      waitd();
      $display("key channel test done");
      complete_run();
   end
endmodule
